// *** hw/sfe_top.sv ***
`timescale 1ns/1ns
`default_nettype none

module sfe_top #(
  parameter int unsigned BULK_ERASE_CYCLES = sfe_pkg::BULK_ERASE_CYCLES
) (
  // system clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // serial programming link
  input  wire logic                          serialProgClock,
  input  wire logic                          serialProgDataIn,
  output logic                               serialProgDataOut,
  output logic                               serialProgDataOe,
  // ordinary protection programming
  input  wire logic                          protSetValid,
  input  wire logic [sfe_pkg::NUM_REGIONS-1:0] codeProtSet,
  input  wire logic [sfe_pkg::NUM_REGIONS-1:0] writeProtSet,
  // erase controls toward the array
  output logic                               bulkEraseBusy,
  output logic [sfe_pkg::NUM_REGIONS-1:0]    bulkEraseRegions,
  output logic                               rowEraseActive,
  output logic [15:0]                        rowEraseIndex,
  // protection state
  output logic [sfe_pkg::NUM_REGIONS-1:0]    codeProtected,
  output logic [sfe_pkg::NUM_REGIONS-1:0]    writeProtected,
  output logic                               dataProtectBit
);

  localparam logic [4:0] LAST_BIT    = 5'(sfe_pkg::WORD_BITS - 1);
  localparam logic [4:0] NIBBLE_LAST = 5'(sfe_pkg::CMD_BITS - 1);

  // link domain state
  logic [4:0]  bitCnt;
  logic [18:0] shiftReg;
  logic [7:0]  wreg;
  logic [21:0] tablePtr;
  logic [7:0]  flashControl;
  logic [7:0]  optLow;
  logic [7:0]  optHigh;
  logic        bulkArmed;
  logic        suspended;
  logic        bulkStartTgl;
  logic        doneMeta;
  logic        doneSync;
  logic        doneSeen;
  logic [17:0] protMeta;
  logic [17:0] protSync;
  logic        rowHigh;

  // link domain decode
  logic [19:0] word;
  logic [3:0]  cmd;
  logic [7:0]  opHi;
  logic [7:0]  opLo;
  logic        wordDone;
  logic        nibbleDone;
  logic        bulkGo;
  logic [7:0]  tblByte;
  logic        fcrOp;
  logic [7:0]  fcrMask;
  logic [8:0]  protAny;
  logic [3:0]  blockBit;
  logic        rowBlocked;
  logic        rowOk;
  logic        rowErasing;

  // system domain state
  logic [1:0]  linkSync;
  logic        startSeen;
  logic        startPulse;
  logic        rowSeen;
  logic        timerBusy;
  logic        timerDone;
  logic        doneTgl;
  logic [8:0]  eraseClr;
  logic [8:0]  eraseRegs;

  // maps a 16-bit option code onto the region vector
  function automatic logic [8:0] regionsOf(input logic [15:0] code);
    logic [8:0] r;
    r = 9'h000;
    if (code == sfe_pkg::OPT_CHIP) begin
      r = sfe_pkg::REGIONS_ALL;
    end else if (code == sfe_pkg::OPT_DATA) begin
      r[sfe_pkg::REG_DATA] = 1'b1;
    end else if (code == sfe_pkg::OPT_BOOT) begin
      r[sfe_pkg::REG_BOOT] = 1'b1;
    end else if (code == sfe_pkg::OPT_CFG) begin
      r[sfe_pkg::REG_CFG] = 1'b1;
    end else if (code[7:0] == sfe_pkg::OPT_BLOCK_LOW) begin
      for (int i = 0; i < sfe_pkg::NUM_BLOCKS; i++) begin
        if (code[15:8] == 8'(1 << i)) begin
          r[sfe_pkg::REG_BLK0 + i] = 1'b1;
        end
      end
    end
    return r;
  endfunction : regionsOf

  // the device never reads data back in this block
  assign serialProgDataOut = 1'b0;
  assign serialProgDataOe  = 1'b0;

  // word assembly: command in the low nibble, operand above
  assign word       = {serialProgDataIn, shiftReg};
  assign cmd        = word[3:0];
  assign opHi       = word[19:12];
  assign opLo       = word[11:4];
  assign wordDone   = !suspended && (bitCnt == LAST_BIT);
  assign nibbleDone = !suspended && (bitCnt == NIBBLE_LAST);
  assign bulkGo     = nibbleDone && bulkArmed &&
                      ({serialProgDataIn, shiftReg[18:16]} ==
                       sfe_pkg::CMD_CORE);
  assign tblByte    = tablePtr[0] ? opHi : opLo;

  // bit set or clear aimed at the flash control register
  assign fcrOp   = (cmd == sfe_pkg::CMD_CORE) &&
                   (opLo == sfe_pkg::FILE_FCR) &&
                   ((opHi[7:4] == sfe_pkg::OP_BSF) ||
                    (opHi[7:4] == sfe_pkg::OP_BCF));
  assign fcrMask = (8'h01 << opHi[3:1]) & sfe_pkg::FCR_IMPL;

  // row protection check against the synchronised protection state
  assign protAny  = protSync[17:9] | protSync[8:0];
  assign blockBit = 4'(tablePtr[sfe_pkg::BLOCK_SHIFT +: 3]) +
                    4'(sfe_pkg::REG_BLK0);
  assign rowBlocked =
    (tablePtr >= sfe_pkg::MEM_END) ||
    ((tablePtr < sfe_pkg::BOOT_END) && protAny[sfe_pkg::REG_BOOT]) ||
    ((tablePtr < sfe_pkg::MEM_END) && protAny[blockBit]);
  assign rowOk = flashControl[sfe_pkg::FCR_CODE] &&
                 !flashControl[sfe_pkg::FCR_CFG] &&
                 flashControl[sfe_pkg::FCR_WRITE_ENABLE_BIT] &&
                 flashControl[sfe_pkg::FCR_ROW] &&
                 !rowBlocked;

  // bit counter and shifter; counter held at zero, shifter frozen while a bulk erase runs
  always_ff @(negedge serialProgClock or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt   <= 5'h00;
      shiftReg <= 19'h00000;
    end else if (suspended || bulkGo) begin
      bitCnt <= 5'h00;
    end else begin
      shiftReg <= {serialProgDataIn, shiftReg[18:1]};
      bitCnt   <= (bitCnt == LAST_BIT) ? 5'h00 : bitCnt + 5'h01;
    end
  end

  // suspend on erase start, resume on the returned done toggle
  always_ff @(negedge serialProgClock or negedge rst_n) begin
    if (!rst_n) begin
      suspended    <= 1'b0;
      bulkStartTgl <= 1'b0;
      doneSeen     <= 1'b0;
    end else begin
      doneSeen <= doneSync;
      if (bulkGo) begin
        suspended    <= 1'b1;
        bulkStartTgl <= ~bulkStartTgl;
      end else if (doneSync != doneSeen) begin
        suspended <= 1'b0;
      end
    end
  end

  // clock-domain return path: done toggle and protection levels
  always_ff @(negedge serialProgClock or negedge rst_n) begin
    if (!rst_n) begin
      doneMeta <= 1'b0;
      doneSync <= 1'b0;
      protMeta <= 18'h00000;
      protSync <= 18'h00000;
    end else begin
      doneMeta <= doneTgl;
      doneSync <= doneMeta;
      protMeta <= {writeProtected, codeProtected};
      protSync <= protMeta;
    end
  end

  // working register and table pointer from core instructions
  always_ff @(negedge serialProgClock or negedge rst_n) begin
    if (!rst_n) begin
      wreg     <= 8'h00;
      tablePtr <= 22'h000000;
    end else if (wordDone && (cmd == sfe_pkg::CMD_CORE)) begin
      if (opHi == sfe_pkg::OP_MOVLW) begin
        wreg <= opLo;
      end else if (opHi == sfe_pkg::OP_MOVWF ||
                   opHi == sfe_pkg::OP_CLRF) begin
        unique case (opLo)
          sfe_pkg::FILE_PTR_U: tablePtr[21:16] <=
            (opHi == sfe_pkg::OP_CLRF) ? 6'h00 : wreg[5:0];
          sfe_pkg::FILE_PTR_H: tablePtr[15:8] <=
            (opHi == sfe_pkg::OP_CLRF) ? 8'h00 : wreg;
          sfe_pkg::FILE_PTR_L: tablePtr[7:0] <=
            (opHi == sfe_pkg::OP_CLRF) ? 8'h00 : wreg;
          default: tablePtr <= tablePtr;
        endcase
      end
    end
  end

  // flash control register; start bit drops as the timed clock falls
  always_ff @(negedge serialProgClock or negedge rst_n) begin
    if (!rst_n) begin
      flashControl <= sfe_pkg::FCR_RESET;
    end else if (nibbleDone && flashControl[sfe_pkg::FCR_START]) begin
      flashControl[sfe_pkg::FCR_START] <= 1'b0;
    end else if (wordDone && fcrOp) begin
      if (opHi[7:4] == sfe_pkg::OP_BCF) begin
        flashControl <= flashControl & ~fcrMask;
      end else if (opHi[3:1] != 3'(sfe_pkg::FCR_START) || rowOk) begin
        flashControl <= flashControl | fcrMask;
      end
    end
  end

  // option bytes by table write; low byte arms the bulk erase
  always_ff @(negedge serialProgClock or negedge rst_n) begin
    if (!rst_n) begin
      optLow    <= sfe_pkg::OPT_RESET;
      optHigh   <= sfe_pkg::OPT_RESET;
      bulkArmed <= 1'b0;
    end else if (nibbleDone) begin
      bulkArmed <= 1'b0;
    end else if (wordDone && (cmd == sfe_pkg::CMD_TBL_WR)) begin
      if (tablePtr == sfe_pkg::OPT_HIGH_ADDR) begin
        optHigh <= tblByte;
      end else if (tablePtr == sfe_pkg::OPT_LOW_ADDR) begin
        optLow    <= tblByte;
        bulkArmed <= 1'b1;
      end
    end
  end

  // fourth rising clock of an armed NOP opens the row erase
  always_ff @(posedge serialProgClock or negedge rst_n) begin
    if (!rst_n) begin
      rowHigh <= 1'b0;
    end else begin
      rowHigh <= flashControl[sfe_pkg::FCR_START] && !suspended &&
                 (bitCnt == NIBBLE_LAST) &&
                 (shiftReg[18:16] == 3'h0);
    end
  end

  // only one input moves per edge, so the gate cannot glitch
  assign rowErasing = rowHigh && flashControl[sfe_pkg::FCR_START];

  // link events into the system clock
  sfe_sync #(
    .WIDTH(2)
  ) u_link_sync (
    .clk  (clk),
    .rst_n(rst_n),
    .d    ({bulkStartTgl, rowErasing}),
    .q    (linkSync)
  );

  assign startPulse = linkSync[1] != startSeen;

  // self-timed bulk erase
  sfe_erase_timer #(
    .CYCLES(BULK_ERASE_CYCLES)
  ) u_timer (
    .clk  (clk),
    .rst_n(rst_n),
    .start(startPulse),
    .busy (timerBusy),
    .done (timerDone)
  );

  assign bulkEraseBusy = timerBusy;

  // option bytes are stable: the link is halted while erasing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      startSeen <= 1'b0;
      eraseRegs <= 9'h000;
      doneTgl   <= 1'b0;
    end else begin
      startSeen <= linkSync[1];
      if (startPulse) begin
        eraseRegs <= regionsOf({optHigh, optLow});
      end else if (timerDone) begin
        eraseRegs <= 9'h000;
        doneTgl   <= ~doneTgl;
      end
    end
  end

  // done trails busy by a cycle, so the shown regions drop with busy
  assign bulkEraseRegions = timerBusy ? eraseRegs : 9'h000;

  // a finished erase clears protection of what it erased
  assign eraseClr = timerDone ? eraseRegs : 9'h000;

  // programming can only protect; erasure alone unprotects
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      codeProtected  <= sfe_pkg::PROT_RESET;
      writeProtected <= sfe_pkg::PROT_RESET;
    end else begin
      codeProtected <= (codeProtected & ~eraseClr) |
                       (protSetValid ? codeProtSet : 9'h000);
      writeProtected <= (writeProtected &
                         ~(eraseClr[sfe_pkg::REG_CFG] ?
                           sfe_pkg::REGIONS_ALL : eraseClr)) |
                        (protSetValid ? writeProtSet : 9'h000);
    end
  end

  // protected is shown low on the data protect bit
  assign dataProtectBit = ~codeProtected[sfe_pkg::REG_DATA];

  // row erase window and its row-aligned index
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rowSeen       <= 1'b0;
      rowEraseIndex <= 16'h0000;
    end else begin
      rowSeen <= linkSync[0];
      if (linkSync[0] && !rowSeen) begin
        rowEraseIndex <= tablePtr[21:sfe_pkg::ROW_SHIFT];
      end
    end
  end

  assign rowEraseActive = rowSeen;

endmodule : sfe_top

`default_nettype wire

// *** hw/sfe_pkg.sv ***
package sfe_pkg;

  // serial instruction framing
  localparam int unsigned WORD_BITS  = 20;
  localparam int unsigned CMD_BITS   = 4;
  localparam logic [3:0]  CMD_CORE   = 4'h0;
  localparam logic [3:0]  CMD_TBL_WR = 4'hC;

  // bulk erase option registers in table space
  localparam logic [21:0] OPT_LOW_ADDR  = 22'h3C0004;
  localparam logic [21:0] OPT_HIGH_ADDR = 22'h3C0005;
  localparam logic [7:0]  OPT_RESET     = 8'h00;

  // bulk erase option codes
  localparam logic [15:0] OPT_CHIP      = 16'h3F8F;
  localparam logic [15:0] OPT_DATA      = 16'h0084;
  localparam logic [15:0] OPT_BOOT      = 16'h0081;
  localparam logic [15:0] OPT_CFG       = 16'h0082;
  localparam logic [7:0]  OPT_BLOCK_LOW = 8'h80;
  localparam int unsigned NUM_BLOCKS    = 6;

  // erase region vector layout
  localparam int unsigned NUM_REGIONS = 9;
  localparam int unsigned REG_BOOT    = 0;
  localparam int unsigned REG_CFG     = 1;
  localparam int unsigned REG_DATA    = 2;
  localparam int unsigned REG_BLK0    = 3;
  localparam logic [8:0]  REGIONS_ALL = 9'h1FF;
  localparam logic [8:0]  PROT_RESET  = 9'h000;

  // core instruction opcodes and file addresses
  localparam logic [7:0] OP_MOVLW   = 8'h0E;
  localparam logic [7:0] OP_MOVWF   = 8'h6E;
  localparam logic [7:0] OP_CLRF    = 8'h6A;
  localparam logic [3:0] OP_BSF     = 4'h8;
  localparam logic [3:0] OP_BCF     = 4'h9;
  localparam logic [7:0] FILE_FCR   = 8'hA6;
  localparam logic [7:0] FILE_PTR_U = 8'hF8;
  localparam logic [7:0] FILE_PTR_H = 8'hF7;
  localparam logic [7:0] FILE_PTR_L = 8'hF6;

  // flash control register bits
  localparam int unsigned FCR_CODE  = 7;
  localparam int unsigned FCR_CFG   = 6;
  localparam int unsigned FCR_ROW   = 4;
  localparam int unsigned FCR_WRITE_ENABLE_BIT  = 2;
  localparam int unsigned FCR_START = 1;
  localparam logic [7:0]  FCR_IMPL  = 8'hD6;
  localparam logic [7:0]  FCR_RESET = 8'h00;

  // code memory layout
  localparam int unsigned ROW_SHIFT   = 6;
  localparam int unsigned BLOCK_SHIFT = 14;
  localparam logic [21:0] BOOT_END    = 22'h000800;
  localparam logic [21:0] MEM_END     = 22'h018000;

  // self-timed bulk erase duration
  localparam int unsigned CLK_PERIOD_NS      = 10;
  localparam int unsigned BULK_ERASE_TIME_US = 5000;
  localparam int unsigned BULK_ERASE_CYCLES  =
    (BULK_ERASE_TIME_US * 1000) / CLK_PERIOD_NS;

endpackage : sfe_pkg

// *** hw/sfe_sync.sv ***
`timescale 1ns/1ns
`default_nettype none

module sfe_sync #(
  parameter int unsigned WIDTH = 1
) (
  // destination clock
  input  wire logic             clk,
  input  wire logic             rst_n,
  // asynchronous level in, synchronised level out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // two flops; only the second one reads the first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : sfe_sync

`default_nettype wire

// *** hw/sfe_erase_timer.sv ***
`timescale 1ns/1ns
`default_nettype none

module sfe_erase_timer #(
  parameter int unsigned CYCLES = 1
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  logic [31:0] cnt;

  // busy for exactly CYCLES clocks after a start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= 32'h0000_0000;
      busy <= 1'b0;
    end else if (start && !busy) begin
      cnt  <= 32'(CYCLES - 1);
      busy <= 1'b1;
    end else if (busy) begin
      if (cnt == 32'h0000_0000) begin
        busy <= 1'b0;
      end else begin
        cnt <= cnt - 32'h0000_0001;
      end
    end
  end

  // one-cycle pulse as busy drops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else begin
      done <= busy && (cnt == 32'h0000_0000);
    end
  end

endmodule : sfe_erase_timer

`default_nettype wire

// *** verification/sfe_top_sva.sv ***
`timescale 1ns/1ns
`default_nettype none

module sfe_top_sva #(
  parameter int unsigned BULK_ERASE_CYCLES = 20
) (
  // clock and reset
  input wire logic                             clk,
  input wire logic                             rst_n,
  // link pins
  input wire logic                             serialProgClock,
  input wire logic                             serialProgDataOe,
  // erase and protection outputs
  input wire logic                             bulkEraseBusy,
  input wire logic [sfe_pkg::NUM_REGIONS-1:0]  bulkEraseRegions,
  input wire logic                             rowEraseActive,
  input wire logic [15:0]                      rowEraseIndex,
  input wire logic [sfe_pkg::NUM_REGIONS-1:0]  codeProtected
);
  logic [31:0] busyCount;

  // counts clk cycles of the running bulk erase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busyCount <= 32'h0;
    end else begin
      busyCount <= bulkEraseBusy ? busyCount + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_regions_in_busy: assert property (
    (bulkEraseRegions != '0) |-> bulkEraseBusy)
    else $error("erase regions shown outside a bulk erase");
  a_busy_length: assert property (
    $fell(bulkEraseBusy) |-> busyCount == 32'(BULK_ERASE_CYCLES))
    else $error("bulk erase length differs from setting");
  a_regions_steady: assert property (
    bulkEraseBusy && $past(bulkEraseBusy) |-> $stable(bulkEraseRegions))
    else $error("erase regions changed during erase");
  a_prot_by_erase: assert property (
    (($past(codeProtected) & ~codeProtected) != '0)
      |-> $past(bulkEraseBusy) || $past(bulkEraseBusy, 2))
    else $error("protection cleared without bulk erase");
  a_row_after_clock: assert property (
    $rose(rowEraseActive) |-> $past(serialProgClock, 2))
    else $error("row erase opened without link clock high");
  a_row_ends_low: assert property (
    (!serialProgClock) [*5] |-> !rowEraseActive)
    else $error("row erase still open after clock fell");
  a_index_steady: assert property (
    rowEraseActive && $past(rowEraseActive) |-> $stable(rowEraseIndex))
    else $error("row index changed while erasing");
  a_row_not_bulk: assert property (
    bulkEraseBusy |-> !rowEraseActive)
    else $error("row erase during bulk erase");
  a_link_input_only: assert property (
    !serialProgDataOe)
    else $error("device drives the data line");
endmodule : sfe_top_sva

bind sfe_top sfe_top_sva #(
  .BULK_ERASE_CYCLES(BULK_ERASE_CYCLES)
) u_sva (
  .clk              (clk),
  .rst_n            (rst_n),
  .serialProgClock  (serialProgClock),
  .serialProgDataOe (serialProgDataOe),
  .bulkEraseBusy    (bulkEraseBusy),
  .bulkEraseRegions (bulkEraseRegions),
  .rowEraseActive   (rowEraseActive),
  .rowEraseIndex    (rowEraseIndex),
  .codeProtected    (codeProtected)
);

`default_nettype wire

// *** verification/sfe_prog_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module sfe_prog_model (
  // serial programming pins
  output logic serialProgClock,
  output logic serialProgDataIn
);
  localparam int HALF_NS      = 24;
  localparam int HOLD_NS      = 4;
  localparam int DISCHARGE_NS = 200;

  // link clock stands low between frames
  initial begin
    serialProgClock  = 1'b0;
    serialProgDataIn = 1'b0;
  end

  // one bit; data leaves its value once the hold time is over
  task automatic send_bit(input logic b, input logic after);
    serialProgClock  = 1'b1;
    serialProgDataIn = b;
    #HALF_NS;
    serialProgClock = 1'b0;
    #HOLD_NS;
    serialProgDataIn = after;
    #(HALF_NS - HOLD_NS);
  endtask : send_bit

  // command nibble then operand, lsb first
  task automatic send_word(input logic [3:0] cmd, input logic [15:0] operand);
    logic [19:0] w;
    w = {operand, cmd};
    for (int i = 0; i < 20; i++) begin
      send_bit(w[i], ~w[i]);
    end
  endtask : send_word

  // loads the table pointer through core instructions
  task automatic set_ptr(input logic [21:0] a);
    send_word(4'h0, {8'h0E, 2'h0, a[21:16]});
    send_word(4'h0, 16'h6EF8);
    send_word(4'h0, {8'h0E, a[15:8]});
    send_word(4'h0, 16'h6EF7);
    send_word(4'h0, {8'h0E, a[7:0]});
    send_word(4'h0, 16'h6EF6);
  endtask : set_ptr

  // nop that starts the bulk erase, clock keeps toggling
  task automatic erase_nop(input int n);
    repeat (4) send_bit(1'b0, 1'b0);
    repeat (n) send_bit(1'b0, 1'b0);
  endtask : erase_nop

  // nop whose fourth clock is held high for the erase time
  task automatic row_nop(input int holdNs);
    repeat (3) send_bit(1'b0, 1'b1);
    serialProgClock  = 1'b1;
    serialProgDataIn = 1'b0;
    #holdNs;
    serialProgClock = 1'b0;
    #DISCHARGE_NS;
    repeat (16) send_bit(1'b0, 1'b1);
  endtask : row_nop
endmodule : sfe_prog_model

`default_nettype wire

// *** verification/sfe_top_tb.sv ***
`timescale 1ns/1ns
`default_nettype none

module sfe_top_tb;
  localparam int BULK_CYCLES = 20;
  localparam int TIME_LIMIT  = 40000;
  localparam logic [15:0] OPTS [11] = '{16'h3F8F, 16'h0084, 16'h0081,
    16'h0082, 16'h0180, 16'h0280, 16'h0480, 16'h0880, 16'h1080, 16'h2080,
    16'h1234};
  localparam logic [8:0] REGS [11] = '{9'h1FF, 9'h004, 9'h001, 9'h002,
    9'h008, 9'h010, 9'h020, 9'h040, 9'h080, 9'h100, 9'h000};

  // design connections
  logic       clk;
  logic       rst_n;
  wire logic  serialProgClock;
  wire logic  serialProgDataIn;
  logic       serialProgDataOe;
  logic       protSetValid;
  logic [8:0] codeProtSet;
  logic [8:0] writeProtSet;
  logic       bulkEraseBusy;
  logic [8:0] bulkEraseRegions;
  logic       rowEraseActive;
  logic [15:0] rowEraseIndex;
  logic [8:0] codeProtected;
  logic [8:0] writeProtected;
  logic       dataProtectBit;
  int         n_fail;
  int         comparisons;
  int         cycles;

  sfe_top #(
    .BULK_ERASE_CYCLES(BULK_CYCLES)
  ) u_dut (
    .clk (clk), .rst_n (rst_n),
    .serialProgClock (serialProgClock), .serialProgDataIn (serialProgDataIn),
    .serialProgDataOut (), .serialProgDataOe (serialProgDataOe),
    .protSetValid (protSetValid), .codeProtSet (codeProtSet),
    .writeProtSet (writeProtSet), .bulkEraseBusy (bulkEraseBusy),
    .bulkEraseRegions (bulkEraseRegions), .rowEraseActive (rowEraseActive),
    .rowEraseIndex (rowEraseIndex), .codeProtected (codeProtected),
    .writeProtected (writeProtected), .dataProtectBit (dataProtectBit)
  );

  sfe_prog_model u_prog (
    .serialProgClock  (serialProgClock),
    .serialProgDataIn (serialProgDataIn)
  );

  // system clock
  always #5 clk = ~clk;

  // cuts a hung run short
  always @(posedge clk) begin
    cycles++;
    if (cycles == TIME_LIMIT) begin
      n_fail++;
      $display("unexpected at %0t: run too long", $time);
      end_sim();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  task automatic do_reset;
    rst_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
  endtask : do_reset

  // ordinary protection programming, one-cycle pulse
  task automatic protect(input logic [8:0] mask);
    codeProtSet  = mask;
    writeProtSet = mask;
    protSetValid = 1'b1;
    @(negedge clk);
    protSetValid = 1'b0;
    @(negedge clk);
  endtask : protect

  // option write high then low, erase nop, watch the erase
  task automatic bulk(input logic [15:0] opt, input logic [8:0] exp);
    logic [8:0] seenRegions;
    int busyLen;
    seenRegions = 9'h000;
    busyLen = 0;
    do_reset();
    protect(9'h1FF);
    check({7'h00, codeProtected}, 16'h01FF, "protect set");
    check({15'h0, dataProtectBit}, 16'h0000, "data flag");
    u_prog.set_ptr(sfe_pkg::OPT_HIGH_ADDR);
    u_prog.send_word(sfe_pkg::CMD_TBL_WR, {opt[15:8], opt[15:8]});
    u_prog.set_ptr(sfe_pkg::OPT_LOW_ADDR);
    u_prog.send_word(sfe_pkg::CMD_TBL_WR, {opt[7:0], opt[7:0]});
    fork
      u_prog.erase_nop(12);
      repeat (200) begin
        @(negedge clk);
        if (bulkEraseBusy === 1'b1) begin
          busyLen++;
          seenRegions = bulkEraseRegions;
        end
      end
    join
    check(16'(busyLen), 16'(BULK_CYCLES), "erase length");
    check({7'h00, seenRegions}, {7'h00, exp}, "regions");
    check({7'h00, codeProtected}, {7'h00, ~exp}, "code prot");
    check({7'h00, writeProtected},
          {7'h00, exp[sfe_pkg::REG_CFG] ? 9'h000 : ~exp}, "wr prot");
  endtask : bulk

  // control bits, pointer, start, then the timed nop
  task automatic row(input logic [21:0] ptr, input logic write_enable_bit,
                     input logic [8:0] prot, input logic expOn);
    do_reset();
    protect(prot);
    u_prog.send_word(4'h0, 16'h8EA6);
    u_prog.send_word(4'h0, 16'h9CA6);
    if (write_enable_bit) begin
      u_prog.send_word(4'h0, 16'h84A6);
    end
    u_prog.send_word(4'h0, 16'h88A6);
    u_prog.set_ptr(ptr);
    u_prog.send_word(4'h0, 16'h82A6);
    fork
      u_prog.row_nop(600);
      begin
        #400;
        @(negedge clk);
        check({15'h0, rowEraseActive}, {15'h0, expOn}, "row open");
        if (expOn) begin
          check(rowEraseIndex, ptr[21:6], "row index");
        end
      end
    join
    check({15'h0, rowEraseActive}, 16'h0000, "row closed");
  endtask : row

  // main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    protSetValid = 1'b0;
    codeProtSet = 9'h000;
    writeProtSet = 9'h000;
    n_fail = 0;
    comparisons = 0;
    cycles = 0;
    do_reset();
    check({7'h00, codeProtected}, 16'h0000, "reset prot");
    check({7'h00, writeProtected}, 16'h0000, "reset wr prot");
    check({15'h0, dataProtectBit}, 16'h0001, "reset data flag");
    check({15'h0, bulkEraseBusy}, 16'h0000, "reset busy");
    check({15'h0, serialProgDataOe}, 16'h0000, "data enable");
    $display("test reset values done");
    for (int i = 0; i < 11; i++) begin
      bulk(OPTS[i], REGS[i]);
    end
    $display("test bulk erase done");
    row(22'h0000FF, 1'b1, 9'h000, 1'b1);
    row(22'h00013F, 1'b1, 9'h000, 1'b1);
    row(22'h017FC0, 1'b1, 9'h000, 1'b1);
    row(22'h018000, 1'b1, 9'h000, 1'b0);
    row(22'h004000, 1'b0, 9'h000, 1'b0);
    row(22'h004000, 1'b1, 9'h1FF, 1'b0);
    $display("test row erase done");
    end_sim();
  end
endmodule : sfe_top_tb

`default_nettype wire
